/* File: cpmc_checker.sv */
// Port checker for the clock and power mode controller.
`timescale 1ns/1ps

module cpmc_chk
(
	input  wire        ref_clk_i,
	input  wire        nrst_i,
	input  wire [15:0] external_wake_interrupts_i,
	input  wire        rtc_alarm_i,
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [31:0] rdata_o,
	input  wire        main_pll_en_o,
	input  wire        usb_pll_en_o,
	input  wire        core_power_en_o,
	input  wire        test_mode_o
);
	reg  [2:0] up_q;
	wire       wake_any = |external_wake_interrupts_i | rtc_alarm_i;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// Saturating age since reset, so the strap latch has surely happened.
	always @(posedge ref_clk_i or negedge nrst_i)
		if (!nrst_i)
			up_q <= 3'd0;
		else if (up_q != 3'd7)
			up_q <= up_q + 3'd1;

	chk_rdata_quiet: assert property (
		!rd_i |=> rdata_o == 32'h0000_0000) else $error("read data without read");
	chk_test_hold: assert property (
		up_q == 3'd7 |-> $stable(test_mode_o)) else $error("test mode moved");
	chk_sleep_hold: assert property (
		!core_power_en_o && !wake_any |=> !core_power_en_o) else $error("sleep left");
	chk_sleep_exit: assert property (
		!core_power_en_o && wake_any |=> core_power_en_o) else $error("wake missed");
	chk_wake_cause: assert property (
		$rose(core_power_en_o) |-> $past(wake_any)) else $error("power back unasked");
	chk_sleep_cause: assert property (
		$fell(core_power_en_o) |-> $past(wr_i) || $past(wr_i, 2)) else $error("power cut");
	chk_usb_pll_on: assert property (
		core_power_en_o |-> usb_pll_en_o) else $error("usb pll off");
	chk_pll_cause: assert property (
		$fell(main_pll_en_o) |-> $past(wr_i) || $past(wr_i, 2) || !core_power_en_o)
		else $error("main pll off unasked");
endmodule // cpmc_chk

bind cpmc_top cpmc_chk u_chk (.ref_clk_i, .nrst_i, .external_wake_interrupts_i,
	.rtc_alarm_i, .wr_i, .rd_i, .rdata_o, .main_pll_en_o, .usb_pll_en_o,
	.core_power_en_o, .test_mode_o);

/* File: cpmc_clk_gate.v */
// Glitch-free clock gate: enable retimed on the falling edge of the clock.
`timescale 1ns/1ps

module cpmc_clk_gate
(
	input  wire clk_i,
	input  wire en_i,
	output wire gclk_o
);

	reg en_q;

	// glitch-free gate
	// The enable is retimed on the falling edge, so it only moves while the clock is low.
	// It has no reset: the output is unknown until the clock first falls.
	always @(negedge clk_i)
	begin
		en_q <= en_i;
	end

	assign gclk_o = clk_i & en_q;

endmodule // cpmc_clk_gate

/* File: cpmc_defs.vh */
// Constants for the clock and power mode controller.
`ifndef CPMC_DEFS_VH
`define CPMC_DEFS_VH

// Register indices on the plain register port.
`define CPMC_ADDR_W          4
`define CPMC_REG_PLLCFG      4'h0
`define CPMC_REG_USBCFG      4'h1
`define CPMC_REG_GATES       4'h2
`define CPMC_REG_MODE        4'h3
`define CPMC_REG_STATUS      4'h4
`define CPMC_REG_DIV         4'h5
`define CPMC_REG_WAKE        4'h6

// Reset values.
`define CPMC_PLLCFG_RST      20'h0_0000
`define CPMC_USBCFG_RST      20'h0_0000
`define CPMC_GATES_RST       16'hFFFF
`define CPMC_DIV_RST         4'h0

// Mode encodings written by software.
`define CPMC_MODE_W          2
`define CPMC_MODE_NORMAL     2'h0
`define CPMC_MODE_SLOW       2'h1
`define CPMC_MODE_IDLE       2'h2
`define CPMC_MODE_SLEEP      2'h3

// Divider field positions.
`define CPMC_DIV_H_LO        0
`define CPMC_DIV_P_BIT       2
`define CPMC_DIV_HW          2

// Lock time in microseconds and in 25 ns cycles (the exact product).
`define CPMC_LOCK_US         300
`define CPMC_CLK_MHZ         40
`define CPMC_LOCK_CYC        (`CPMC_LOCK_US * `CPMC_CLK_MHZ)

// Boot strap decoding.
`define CPMC_BOOT_TEST       2'h3

`endif

/* File: cpmc_srcs.sv */
// Model of the raw and PLL clock sources feeding the controller.
`timescale 1ns/1ps

module cpmc_srcs
(
	output reg xtal_o,
	output reg ext_o,
	output reg mpll_o,
	output reg usb_pll_o
);
	// Distinct free-running rates, so the source in use shows in edge counts.
	initial
	begin
		xtal_o = 1'b0;
		ext_o = 1'b0;
		mpll_o = 1'b0;
		usb_pll_o = 1'b0;
	end
	always #40 xtal_o = ~xtal_o;
	always #30 ext_o = ~ext_o;
	always #5 mpll_o = ~mpll_o;
	always #10 usb_pll_o = ~usb_pll_o;
endmodule // cpmc_srcs

/* File: cpmc_top.v */
// Clock and power mode controller: source select, PLL hand-over, gating and modes.
//
// Contract
// - Produce core, system-bus and peripheral-bus clocks.
// - Main PLL feeds core clocks; second PLL gives 48 MHz USB clock.
// - Software gates each peripheral clock; slow clocks without any PLL (the code keeps the USB PLL on in slow mode).
// - Four software modes: normal, slow, idle, sleep.
// - Normal mode clocks CPU and all ungated peripherals.
// - Slow mode drives core clock straight from external source.
// - Idle mode stops only the core clock to the processor.
// - Any processor interrupt ends idle and restores core clock.
// - Sleep removes internal power; only wake-up logic stays on.
// - Sleep exits only on external wake lines 15..0 or alarm.
// - Clock-select boot pins latched at reset release and held.
// - Boot selection maps main and USB sources; both PLLs on.
// - Main PLL output unused until software writes its configuration.
// - Boot mode low pins 11 turn clock-select pins into test mode.
// - Changing PLL dividers in normal mode withholds clocks for lock time.
// - USB clock low during USB PLL lock, then 48 MHz from PLL.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps

`include "cpmc_defs.vh"

module cpmc_top
#(
	parameter NGATE    = 16,
	parameter LOCK_CYC = `CPMC_LOCK_CYC
)
(
	input  wire                    ref_clk_i,
	input  wire                    nrst_i,
	input  wire                    crystal_clock_input_i,
	input  wire                    external_clock_input_i,
	input  wire                    main_pll_clk_i,
	input  wire                    usb_pll_clk_i,
	input  wire [1:0]              clock_select_boot_pins_i,
	input  wire [1:0]              boot_mode_low_pins_i,
	input  wire                    cpu_irq_i,
	input  wire [15:0]             external_wake_interrupts_i,
	input  wire                    rtc_alarm_i,
	input  wire [`CPMC_ADDR_W-1:0] addr_i,
	input  wire [31:0]             wdata_i,
	input  wire                    wr_i,
	input  wire                    rd_i,
	output reg  [31:0]             rdata_o,
	output wire                    core_clock_o,
	output wire                    sys_bus_clk_o,
	output wire                    per_bus_clk_o,
	output wire [NGATE-1:0]        periph_clk_o,
	output wire                    usb_clock_o,
	output reg                     main_pll_en_o,
	output reg                     usb_pll_en_o,
	output reg                     core_power_en_o,
	output reg                     test_mode_o
);

	localparam CW = 20;

	// Mode state, one-hot.
	localparam ST_NORMAL = 4'b0001;
	localparam ST_SLOW   = 4'b0010;
	localparam ST_IDLE   = 4'b0100;
	localparam ST_SLEEP  = 4'b1000;

	reg  [1:0]       rst_sync_q;
	wire             rst_n = rst_sync_q[1];
	reg              boot_done_q;
	reg  [1:0]       clk_sel_q;
	reg  [19:0]      pllcfg_q;
	reg  [19:0]      usbcfg_q;
	reg  [NGATE-1:0] gates_q;
	reg  [3:0]       div_q;
	reg  [3:0]       state_q;
	reg  [3:0]       state_d;
	reg              pll_valid_q;
	reg              usb_valid_q;
	reg  [CW-1:0]    lock_cnt_q;
	reg  [CW-1:0]    ulock_cnt_q;
	reg  [16:0]      wake_src_q;
	reg  [3:0]       div_cnt_q;
	reg              hclk_en_q;
	reg              pclk_en_q;

	// Decode of a register index, used by the write and read paths.
	function hit;
		input [`CPMC_ADDR_W-1:0] a;
		input [`CPMC_ADDR_W-1:0] r;
		begin
			hit = (a == r);
		end
	endfunction

	// Reset is released through two flops; the second is the only user.
	always @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	// strap capture
	// Straps are taken on the first clock after release, never under reset.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			boot_done_q <= 1'b0;
			clk_sel_q   <= 2'b00;
			test_mode_o <= 1'b0;
		end
		else if (!boot_done_q)
		begin
			boot_done_q <= 1'b1;
			clk_sel_q   <= clock_select_boot_pins_i;
			test_mode_o <= (boot_mode_low_pins_i == `CPMC_BOOT_TEST);
		end
	end

	// source selection
	// High bit picks the main source, low bit the USB source; 1 means external.
	wire main_ext_clk = clk_sel_q[1] ? external_clock_input_i : crystal_clock_input_i;
	wire usb_ext_clk  = clk_sel_q[0] ? external_clock_input_i : crystal_clock_input_i;

	wire wake_evt = (|external_wake_interrupts_i) | rtc_alarm_i;

	// Software writes; mode writes handled in the state logic below.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pllcfg_q <= `CPMC_PLLCFG_RST;
			usbcfg_q <= `CPMC_USBCFG_RST;
			gates_q  <= `CPMC_GATES_RST;
			div_q    <= `CPMC_DIV_RST;
		end
		else if (wr_i)
		begin
			if (hit(addr_i, `CPMC_REG_PLLCFG))
				pllcfg_q <= wdata_i[19:0];
			if (hit(addr_i, `CPMC_REG_USBCFG))
				usbcfg_q <= wdata_i[19:0];
			if (hit(addr_i, `CPMC_REG_GATES))
				gates_q <= wdata_i[NGATE-1:0];
			if (hit(addr_i, `CPMC_REG_DIV))
				div_q <= wdata_i[3:0];
		end
	end

	wire pll_wr = wr_i & hit(addr_i, `CPMC_REG_PLLCFG);
	wire usb_wr = wr_i & hit(addr_i, `CPMC_REG_USBCFG);

	// lock wait
	// Any PLLCFG write, same value too, restarts the lock count and holds the core clock off.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pll_valid_q <= 1'b0;
			lock_cnt_q  <= {CW{1'b0}};
		end
		else if (pll_wr)
		begin
			pll_valid_q <= 1'b1;
			lock_cnt_q  <= LOCK_CYC[CW-1:0];
		end
		else if (lock_cnt_q != {CW{1'b0}})
			lock_cnt_q <= lock_cnt_q - {{(CW-1){1'b0}}, 1'b1};
	end

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			usb_valid_q <= 1'b0;
			ulock_cnt_q <= {CW{1'b0}};
		end
		else if (usb_wr)
		begin
			usb_valid_q <= 1'b1;
			ulock_cnt_q <= LOCK_CYC[CW-1:0];
		end
		else if (ulock_cnt_q != {CW{1'b0}})
			ulock_cnt_q <= ulock_cnt_q - {{(CW-1){1'b0}}, 1'b1};
	end

	wire locking  = (lock_cnt_q != {CW{1'b0}});
	wire ulocking = (ulock_cnt_q != {CW{1'b0}});
	wire mode_wr  = wr_i & hit(addr_i, `CPMC_REG_MODE);

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_NORMAL, ST_SLOW:
			begin
				if (mode_wr)
				begin
					case (wdata_i[`CPMC_MODE_W-1:0])
						`CPMC_MODE_SLOW:  state_d = ST_SLOW;
						`CPMC_MODE_IDLE:  state_d = ST_IDLE;
						`CPMC_MODE_SLEEP: state_d = ST_SLEEP;
						default:          state_d = ST_NORMAL;
					endcase
				end
			end
			ST_IDLE:
			begin
				if (cpu_irq_i)
					state_d = ST_NORMAL;
			end
			ST_SLEEP:
			begin
				if (wake_evt)
					state_d = ST_NORMAL;
			end
			default:
				state_d = ST_NORMAL;
		endcase
	end

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= ST_NORMAL;
		else
			state_q <= state_d;
	end

	// wake capture
	// Sticky so software sees what woke the core; a new event beats a clear.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			wake_src_q <= 17'h0_0000;
		else if (state_q == ST_SLEEP && wake_evt)
			wake_src_q <= wake_src_q | {rtc_alarm_i, external_wake_interrupts_i};
		else if (wr_i && hit(addr_i, `CPMC_REG_WAKE))
			wake_src_q <= wake_src_q & ~wdata_i[16:0];
	end

	// PLL enables
	// Slow mode turns the main PLL off to save its power; sleep turns both off.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_power_en_o <= 1'b1;
			main_pll_en_o   <= 1'b1;
			usb_pll_en_o    <= 1'b1;
		end
		else
		begin
			core_power_en_o <= (state_d != ST_SLEEP);
			main_pll_en_o   <= (state_d != ST_SLEEP) && (state_d != ST_SLOW);
			usb_pll_en_o    <= (state_d != ST_SLEEP);
		end
	end

	// glitch-free switch
	// Hand-over to the PLL happens under the lock gate; a slow-mode switch does not.
	wire use_pll   = pll_valid_q & (state_q != ST_SLOW);
	wire root_clk  = use_pll ? main_pll_clk_i : main_ext_clk;
	wire root_on   = !locking && core_power_en_o;

	// derived clocks
	// Bus enables count ref_clk edges: a coarse ratio, not phase-aligned to the root.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_q <= 4'h0;
			hclk_en_q <= 1'b1;
			pclk_en_q <= 1'b1;
		end
		else
		begin
			div_cnt_q <= div_cnt_q + 4'h1;
			hclk_en_q <= ((div_cnt_q & ((4'h1 << div_q[1:0]) - 4'h1)) == 4'h0);
			pclk_en_q <= ((div_cnt_q & ((4'h1 <<
				({1'b0, div_q[1:0]} + {2'h0, div_q[`CPMC_DIV_P_BIT]})) - 4'h1)) == 4'h0);
		end
	end

	cpmc_clk_gate u_core_gate
	(
		.clk_i  (root_clk),
		.en_i   (root_on && (state_q != ST_IDLE)),
		.gclk_o (core_clock_o)
	);

	cpmc_clk_gate u_hclk_gate
	(
		.clk_i  (root_clk),
		.en_i   (root_on && hclk_en_q),
		.gclk_o (sys_bus_clk_o)
	);

	cpmc_clk_gate u_pclk_gate
	(
		.clk_i  (root_clk),
		.en_i   (root_on && pclk_en_q),
		.gclk_o (per_bus_clk_o)
	);

	genvar g;
	generate
		for (g = 0; g < NGATE; g = g + 1)
		begin : g_gate
			cpmc_clk_gate u_gate
			(
				.clk_i  (per_bus_clk_o),
				.en_i   (gates_q[g]),
				.gclk_o (periph_clk_o[g])
			);
		end
	endgenerate

	// USB clock
	// Before configuration the raw source is passed; during lock it is held low.
	wire usb_root = usb_valid_q ? usb_pll_clk_i : usb_ext_clk;
	cpmc_clk_gate u_usb_gate
	(
		.clk_i  (usb_root),
		.en_i   (!ulocking && usb_pll_en_o),
		.gclk_o (usb_clock_o)
	);

	// Read data stand only in the cycle after the read strobe.
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_o <= 32'h0000_0000;
		else if (!rd_i)
			rdata_o <= 32'h0000_0000;
		else if (hit(addr_i, `CPMC_REG_PLLCFG))
			rdata_o <= {12'h000, pllcfg_q};
		else if (hit(addr_i, `CPMC_REG_USBCFG))
			rdata_o <= {12'h000, usbcfg_q};
		else if (hit(addr_i, `CPMC_REG_GATES))
			rdata_o <= {{(32-NGATE){1'b0}}, gates_q};
		else if (hit(addr_i, `CPMC_REG_MODE))
			rdata_o <= {28'h000_0000, state_q};
		else if (hit(addr_i, `CPMC_REG_STATUS))
			rdata_o <= {25'h000_0000, test_mode_o, clk_sel_q, ulocking, locking,
				usb_valid_q, pll_valid_q};
		else if (hit(addr_i, `CPMC_REG_DIV))
			rdata_o <= {28'h000_0000, div_q};
		else if (hit(addr_i, `CPMC_REG_WAKE))
			rdata_o <= {15'h0000, wake_src_q};
		else
			rdata_o <= 32'h0000_0000;
	end
endmodule // cpmc_top

/* File: tb_top.sv */
// Bench for the clock and power mode controller.
`timescale 1ns/1ps
`include "cpmc_defs.vh"

module tb_top;
	reg         clk;
	reg         nrst;
	reg  [1:0]  sel;
	reg  [1:0]  bml;
	reg         irq;
	reg  [15:0] ewk;
	reg         rtc;
	reg  [3:0]  addr;
	reg  [31:0] wdata;
	reg         wr;
	reg         rd;
	wire [31:0] rdata;
	wire [15:0] pc;
	wire        xt, ex, mp, up, cc, pb, sb, uc, mpe, upe, cpe, tm;
	integer     fails, total_checks, n_c, n_u, n_p0, n_p1, n_b, n_s, i;

	cpmc_srcs SRC (.xtal_o(xt), .ext_o(ex), .mpll_o(mp), .usb_pll_o(up));
	cpmc_top #(.LOCK_CYC(60)) DUT (.ref_clk_i(clk), .nrst_i(nrst),
		.crystal_clock_input_i(xt), .external_clock_input_i(ex), .main_pll_clk_i(mp),
		.usb_pll_clk_i(up), .clock_select_boot_pins_i(sel), .boot_mode_low_pins_i(bml),
		.cpu_irq_i(irq), .external_wake_interrupts_i(ewk), .rtc_alarm_i(rtc),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.core_clock_o(cc), .sys_bus_clk_o(sb), .per_bus_clk_o(pb), .periph_clk_o(pc),
		.usb_clock_o(uc), .main_pll_en_o(mpe), .usb_pll_en_o(upe), .core_power_en_o(cpe),
		.test_mode_o(tm));

	// Reference clock and edge counters on the gated outputs.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge cc) n_c = n_c + 1;
	always @(posedge uc) n_u = n_u + 1;
	always @(posedge pc[0]) n_p0 = n_p0 + 1;
	always @(posedge pc[1]) n_p1 = n_p1 + 1;
	always @(posedge pb) n_b = n_b + 1;
	always @(posedge sb) n_s = n_s + 1;

	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			fails = fails + 1;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	end
	endtask

	task rng(input string nm, input integer lo, input integer hi, input integer g);
	begin
		total_checks = total_checks + 1;
		if (g < lo || g > hi)
		begin
			fails = fails + 1;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	end
	endtask

	// Edges seen over 1000 ns: crystal 11..14, external 15..18.
	task src(input string nm, input e, input integer g);
		rng(nm, e ? 15 : 11, e ? 18 : 14, g);
	endtask

	task meas;
	begin
		n_c = 0;
		n_u = 0;
		n_p0 = 0;
		n_p1 = 0;
		n_b = 0;
		n_s = 0;
		repeat (40) @(posedge clk);
	end
	endtask

	task bw(input [3:0] a, input [31:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask

	task br(input [3:0] a, input [31:0] e);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	end
	endtask

	// Straps are held through reset and for a while after release.
	task rst(input [1:0] s, input [1:0] b);
	begin
		@(posedge clk);
		nrst <= 1'b0;
		sel <= s;
		bml <= b;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
	end
	endtask

	// Every clock-select strap code, with the pins moved after latching; then the test-mode code.
	task t_boot;
	begin
		for (i = 0; i < 4; i = i + 1)
		begin
			rst(i[1:0], 2'b00);
			sel <= ~i[1:0];
			br(`CPMC_REG_STATUS, {26'h0, i[1:0], 4'h0});
			meas;
			src("core", i[1], n_c);
			src("usb", i[0], n_u);
		end
		rst(2'b01, 2'b11);
		chk("test", 32'h1, tm);
		br(`CPMC_REG_STATUS, 32'h0000_0050);
	end
	endtask

	// Hand-over to the PLL, then a divider change in normal mode.
	task t_pll;
	begin
		rst(2'b00, 2'b00);
		for (i = 0; i < 2; i = i + 1)
		begin
			bw(`CPMC_REG_PLLCFG, i ? 32'h0001_2345 : 32'h0000_0000);
			br(`CPMC_REG_PLLCFG, i ? 32'h0001_2345 : 32'h0000_0000);
			if (i == 0)
				br(`CPMC_REG_STATUS, 32'h0000_0005);
			meas;
			rng("core", 0, 0, n_c);
			repeat (30) @(posedge clk);
			br(`CPMC_REG_STATUS, 32'h0000_0001);
			meas;
			rng("core", 95, 101, n_c);
			rng("pbus", 95, 101, n_b);
			rng("sbus", 95, 101, n_s);
		end
	end
	endtask

	task t_usb;
	begin
		bw(`CPMC_REG_USBCFG, 32'h0000_0001);
		br(`CPMC_REG_STATUS, 32'h0000_000B);
		meas;
		rng("usb", 0, 0, n_u);
		chk("usb", 32'h0, uc);
		repeat (30) @(posedge clk);
		br(`CPMC_REG_STATUS, 32'h0000_0003);
		meas;
		rng("usb", 48, 51, n_u);
	end
	endtask

	task t_gate;
	begin
		br(`CPMC_REG_GATES, 32'h0000_FFFF);
		bw(`CPMC_REG_GATES, 32'h0000_FFFE);
		br(`CPMC_REG_GATES, 32'h0000_FFFE);
		br(4'hF, 32'h0000_0000);
		meas;
		rng("gate0", 0, 0, n_p0);
		rng("gate1", 1, 999, n_p1);
	end
	endtask

	// Largest divider code, so the peripheral-bus shift reaches four (one in 16).
	task t_div;
	begin
		bw(`CPMC_REG_DIV, 32'h0000_0007);
		br(`CPMC_REG_DIV, 32'h0000_0007);
		meas;
		rng("sbus", 9, 16, n_s);
		rng("pbus", 3, 10, n_b);
		rng("gate1", 3, 10, n_p1);
		bw(`CPMC_REG_DIV, 32'h0000_0000);
	end
	endtask

	task t_mode;
	begin
		bw(`CPMC_REG_MODE, `CPMC_MODE_SLOW);
		br(`CPMC_REG_MODE, 32'h0000_0002);
		chk("mpll", 32'h0, mpe);
		meas;
		src("slow", 1'b0, n_c);
		bw(`CPMC_REG_MODE, `CPMC_MODE_NORMAL);
		br(`CPMC_REG_MODE, 32'h0000_0001);
		bw(`CPMC_REG_MODE, `CPMC_MODE_IDLE);
		bw(`CPMC_REG_MODE, `CPMC_MODE_NORMAL);
		br(`CPMC_REG_MODE, 32'h0000_0004);
		meas;
		rng("idle", 0, 0, n_c);
		rng("gate1", 1, 999, n_p1);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		br(`CPMC_REG_MODE, 32'h0000_0001);
		for (i = 0; i < 2; i = i + 1)
		begin
			bw(`CPMC_REG_MODE, `CPMC_MODE_SLEEP);
			irq <= 1'b1;
			repeat (3) @(posedge clk);
			irq <= 1'b0;
			{rtc, ewk} <= i ? 17'h1_0000 : 17'h0_8000;
			#1 chk("pwr", 32'h0, cpe);
			chk("usb_pll", 32'h0, upe);
			@(posedge clk);
			{rtc, ewk} <= 17'h0_0000;
			@(posedge clk);
			#1 chk("pwr", 32'h1, cpe);
			chk("usb_pll", 32'h1, upe);
			br(`CPMC_REG_WAKE, i ? 32'h0001_0000 : 32'h0000_8000);
			bw(`CPMC_REG_WAKE, 32'h0001_FFFF);
		end
	end
	endtask

	task complete_run;
	begin
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	// Main sequence; every wait in it is a fixed count.
	initial
	begin
		{nrst, sel, bml, irq, ewk, rtc, addr, wdata, wr, rd} = 0;
		fails = 0;
		total_checks = 0;
		t_boot;
		t_pll;
		t_usb;
		t_gate;
		t_div;
		t_mode;
		complete_run;
	end
endmodule // tb_top
